// file: common/lfp_pkg.sv
package lfp_pkg;

	typedef enum logic [2:0] {
		LFP_IDLE     = 3'h0,
		LFP_FL_SETUP = 3'h1,
		LFP_FL_STRB  = 3'h2,
		LFP_FL_HOLD  = 3'h3,
		LFP_ROM_LOW  = 3'h4,
		LFP_ROM_HIGH = 3'h5,
		LFP_ROM_END  = 3'h6
	} lfp_phase_type;

	typedef struct packed {
		logic        write;
		logic [16:0] addr;
		logic [7:0]  wdata;
	} lfp_flash_req_type;

	typedef struct packed {
		logic [7:0] data;
		logic       rom_dout;
		logic       clk_strap;
		logic       pwr_strap;
	} lfp_pins_in_type;

	typedef struct packed {
		lfp_phase_type phase;
		logic [7:0]    cnt;
		logic          straps_done;
		logic          clk_strap;
		logic          pwr_strap;
		logic [16:0]   flash_address_bus;
		logic [16:0]   fla_oe;
		logic [7:0]    fld_o;
		logic          fld_oe;
		logic          write;
		logic          cs_n;
		logic          rd_n;
		logic          wr_n;
		logic          rom_sel;
		logic          last;
		logic          flash_ack;
		logic [7:0]    rdata;
		logic          rom_ack;
		logic          rom_bit;
	} lfp_state_type;

endpackage

// file: common/lfp_regs.svh
// Functional notes
// RULE1 - Eight-bit flash data bus, driven on writes, released on reads.
// RULE2 - Seventeen byte address outputs reach the whole 128 Kbyte flash; with the bit 7 strap high, bit 16 carries the clock.
// RULE3 - Address bit 7 pin sampled at reset; high selects 25 MHz clock on bit 16.
// RULE4 - After reset the bit 7 pin is an ordinary address output.
// RULE5 - Bit 15 pin is address for flash, shift clock for serial ROM.
// RULE6 - Bit 14 pin is address for flash, released as ROM data input otherwise.
// RULE7 - Bit 13 pin is address for flash, data toward the ROM otherwise.
// RULE8 - Bit 1 pin sampled at reset as standby power strap, else address.
// RULE9 - Serial ROM select is asserted during every ROM access.
// RULE10 - Active-low flash select held for the whole flash access only.
// RULE11 - Active-low read enable asserted only during flash reads.
// RULE12 - Active-low write enable asserted only during flash writes.
// RULE13 - Flash and ROM accesses never overlap; flash select off while ROM selected.
`ifndef LFP_REGS_SVH
`define LFP_REGS_SVH

`define LFP_ADDR_W        17
`define LFP_DATA_W        8
`define LFP_CNT_W         8
`define LFP_SYNC_DEPTH    3
`define LFP_CLK_MHZ       20
`define LFP_FL_STROBE_NS  120
`define LFP_FL_STROBE_CYC ((`LFP_FL_STROBE_NS * `LFP_CLK_MHZ + 999) / 1000)
`define LFP_ROM_HALF_NS   1000
`define LFP_ROM_HALF_CYC  ((`LFP_ROM_HALF_NS * `LFP_CLK_MHZ + 999) / 1000)

`define LFP_BIT_AUXCLK    16
`define LFP_BIT_SK        15
`define LFP_BIT_DO        14
`define LFP_BIT_DI        13
`define LFP_BIT_CLKSTRAP  7
`define LFP_BIT_PWRSTRAP  1

`define LFP_RST_ADDR      17'h00000
`define LFP_RST_OE        17'h00000
`define LFP_ALL_OE        17'h1FFFF

`endif

// file: hdl/lfp_pin_sync.sv
`timescale 1ns/1ns
module lfp_pin_sync #(
	parameter int WIDTH = 11
) (
	input  wire logic             ref_clk,  // Block clock
	input  wire logic [WIDTH-1:0] pin_in,   // Asynchronous pin levels
	output logic      [WIDTH-1:0] pin_out   // Filtered levels
);
	// No reset on purpose: straps must flow through while reset is held
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_reg;

	always_ff @(posedge ref_clk) begin
		s1_reg <= pin_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (s2_reg[i] == s3_reg[i]) begin
					out_reg[i] <= s3_reg[i];
				end
			end
		end
	endgenerate

	assign pin_out = out_reg;
endmodule // lfp_pin_sync

// file: hdl/lfp_port.sv
`timescale 1ns/1ns
`include "lfp_regs.svh"
module lfp_port (
	input  wire logic                      ref_clk,              // 20 MHz clock
	input  wire logic                      reset,                // Async, active high
	input  wire logic                      aux_clk_in,           // 25 MHz source
	input  wire logic                      flash_req,            // Flash access request
	input  wire lfp_pkg::lfp_flash_req_type flash_cmd,           // Write flag, address, data
	output logic                           flash_ack,            // Flash access done
	output logic [7:0]                     flash_rdata,          // Read data
	input  wire logic                      rom_req,              // Shift one ROM bit
	input  wire logic                      rom_di,               // Bit toward ROM
	input  wire logic                      rom_last,             // Drop select after bit
	output logic                           rom_ack,              // ROM bit done
	output logic                           rom_do,               // Bit from ROM
	output logic                           aux_clock_strap,      // Strap: clock on pin 16
	output logic                           standby_power_strap,  // Strap: auxiliary power
	output logic                           straps_valid,         // Straps captured
	input  wire logic [7:0]                flash_data_bus_i,     // Data pins in
	output logic [7:0]                     flash_data_bus_o,     // Data pins out
	output logic                           flash_data_bus_oe,    // Data pins enable
	input  wire logic [16:0]               flash_address_bus_i,  // Address pins in
	output logic [16:0]                    flash_address_bus_o,  // Address pins out
	output logic [16:0]                    flash_address_bus_oe, // Address pins enable
	output logic                           serial_rom_select,    // ROM chip select
	output logic                           flash_select_n,       // Flash chip select
	output logic                           flash_read_enable_n,  // Flash output enable
	output logic                           flash_write_enable_n  // Flash write enable
);
	lfp_pkg::lfp_state_type   r_reg;
	lfp_pkg::lfp_state_type   r_next;
	lfp_pkg::lfp_pins_in_type syn;

	localparam logic [7:0] STRB_CYC = 8'(`LFP_FL_STROBE_CYC);
	localparam logic [7:0] HALF_CYC = 8'(`LFP_ROM_HALF_CYC);
	localparam logic [7:0] SYNC_CYC = 8'(`LFP_SYNC_DEPTH);

	lfp_pin_sync #(
		.WIDTH(11)
	) u_sync (
		.ref_clk(ref_clk),
		.pin_in ({flash_data_bus_i, flash_address_bus_i[`LFP_BIT_DO],
			flash_address_bus_i[`LFP_BIT_CLKSTRAP], flash_address_bus_i[`LFP_BIT_PWRSTRAP]}),
		.pin_out(syn)
	);

	always_comb begin
		r_next = r_reg;
		r_next.flash_ack = 1'b0;
		r_next.rom_ack = 1'b0;
		case (r_reg.phase)
			lfp_pkg::LFP_IDLE: begin
				if (!r_reg.straps_done) begin
					// First cycle after release: pins still float, synchroniser holds the straps
					r_next.straps_done = 1'b1;
					r_next.clk_strap = syn.clk_strap; // RULE3
					r_next.pwr_strap = syn.pwr_strap; // RULE8
					r_next.fla_oe = `LFP_ALL_OE; // RULE4
				end else if (flash_req && !r_reg.rom_sel) begin // RULE13
					r_next.phase = lfp_pkg::LFP_FL_SETUP;
					r_next.flash_address_bus = flash_cmd.addr; // RULE2
					r_next.fla_oe = `LFP_ALL_OE;
					r_next.fld_o = flash_cmd.wdata;
					r_next.fld_oe = flash_cmd.write; // RULE1
					r_next.write = flash_cmd.write;
					r_next.cs_n = 1'b0; // RULE10
				end else if (rom_req) begin
					r_next.phase = lfp_pkg::LFP_ROM_LOW;
					r_next.rom_sel = 1'b1; // RULE9
					r_next.flash_address_bus[`LFP_BIT_SK] = 1'b0;
					r_next.flash_address_bus[`LFP_BIT_DI] = rom_di; // RULE7
					r_next.fla_oe[`LFP_BIT_DO] = 1'b0; // RULE6
					r_next.last = rom_last;
					r_next.cnt = HALF_CYC - 8'h01;
				end
			end
			lfp_pkg::LFP_FL_SETUP: begin
				r_next.phase = lfp_pkg::LFP_FL_STRB;
				r_next.rd_n = r_reg.write; // RULE11
				r_next.wr_n = !r_reg.write; // RULE12
				// Reads stretch the strobe to cover the pin synchroniser
				r_next.cnt = r_reg.write ? STRB_CYC - 8'h01 : STRB_CYC + SYNC_CYC - 8'h01;
			end
			lfp_pkg::LFP_FL_STRB: begin
				if (r_reg.cnt == 8'h00) begin
					r_next.phase = lfp_pkg::LFP_FL_HOLD;
					r_next.rd_n = 1'b1;
					r_next.wr_n = 1'b1;
					if (!r_reg.write) begin
						r_next.rdata = syn.data; // RULE1
					end
				end else begin
					r_next.cnt = r_reg.cnt - 8'h01;
				end
			end
			lfp_pkg::LFP_FL_HOLD: begin
				r_next.phase = lfp_pkg::LFP_IDLE;
				r_next.cs_n = 1'b1; // RULE10
				r_next.fld_oe = 1'b0;
				r_next.flash_ack = 1'b1;
			end
			lfp_pkg::LFP_ROM_LOW: begin
				if (r_reg.cnt == 8'h00) begin
					r_next.phase = lfp_pkg::LFP_ROM_HIGH;
					r_next.flash_address_bus[`LFP_BIT_SK] = 1'b1; // RULE5
					r_next.cnt = HALF_CYC - 8'h01;
				end else begin
					r_next.cnt = r_reg.cnt - 8'h01;
				end
			end
			lfp_pkg::LFP_ROM_HIGH: begin
				if (r_reg.cnt == 8'h00) begin
					r_next.flash_address_bus[`LFP_BIT_SK] = 1'b0; // RULE5
					r_next.rom_bit = syn.rom_dout; // RULE6
					r_next.rom_ack = 1'b1;
					r_next.cnt = HALF_CYC - 8'h01;
					r_next.phase = r_reg.last ? lfp_pkg::LFP_ROM_END : lfp_pkg::LFP_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - 8'h01;
				end
			end
			lfp_pkg::LFP_ROM_END: begin
				if (r_reg.cnt == 8'h00) begin
					r_next.phase = lfp_pkg::LFP_IDLE;
					r_next.rom_sel = 1'b0; // RULE13
					r_next.fla_oe = `LFP_ALL_OE;
				end else begin
					r_next.cnt = r_reg.cnt - 8'h01;
				end
			end
			default: begin
				r_next.phase = lfp_pkg::LFP_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_reg <= '{phase: lfp_pkg::LFP_IDLE, cnt: 8'h00, straps_done: 1'b0,
				clk_strap: 1'b0, pwr_strap: 1'b0, flash_address_bus: `LFP_RST_ADDR, fla_oe: `LFP_RST_OE,
				fld_o: 8'h00, fld_oe: 1'b0, write: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
				wr_n: 1'b1, rom_sel: 1'b0, last: 1'b0, flash_ack: 1'b0, rdata: 8'h00,
				rom_ack: 1'b0, rom_bit: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// The 25 MHz source cannot be retimed at 20 MHz, so only its select is a flop
	assign flash_address_bus_o = {r_reg.clk_strap ? aux_clk_in : r_reg.flash_address_bus[`LFP_BIT_AUXCLK],
		r_reg.flash_address_bus[15:0]}; // RULE3
	assign flash_address_bus_oe = r_reg.fla_oe;
	assign flash_data_bus_o     = r_reg.fld_o;
	assign flash_data_bus_oe    = r_reg.fld_oe;
	assign serial_rom_select    = r_reg.rom_sel;
	assign flash_select_n       = r_reg.cs_n;
	assign flash_read_enable_n  = r_reg.rd_n;
	assign flash_write_enable_n = r_reg.wr_n;
	assign flash_ack            = r_reg.flash_ack;
	assign flash_rdata          = r_reg.rdata;
	assign rom_ack              = r_reg.rom_ack;
	assign rom_do               = r_reg.rom_bit;
	assign aux_clock_strap      = r_reg.clk_strap;
	assign standby_power_strap  = r_reg.pwr_strap;
	assign straps_valid         = r_reg.straps_done;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	excl_select_a: assert property (serial_rom_select |-> flash_select_n) // RULE13
		else $error("flash selected during ROM access");
	read_enable_a: assert property (!flash_read_enable_n |-> !flash_select_n
		&& !flash_data_bus_oe && flash_write_enable_n) // RULE11
		else $error("read enable outside flash read");
	write_enable_a: assert property (!flash_write_enable_n |-> !flash_select_n
		&& flash_data_bus_oe) // RULE12
		else $error("write enable outside flash write");
	data_drive_a: assert property (flash_data_bus_oe |-> !flash_select_n) // RULE1
		else $error("data bus driven outside flash write");
	select_span_a: assert property ($fell(flash_select_n) |=>
		(!flash_read_enable_n || !flash_write_enable_n)) // RULE10
		else $error("no strobe after flash select");
	ack_deselect_a: assert property (flash_ack |-> $rose(flash_select_n)) // RULE10
		else $error("flash select not released at ack");
	rom_release_a: assert property (serial_rom_select |-> !flash_address_bus_oe[14]) // RULE6
		else $error("ROM data pin driven during ROM access");
	rom_clock_a: assert property ($rose(flash_address_bus_o[15]) && serial_rom_select
		|-> $stable(flash_address_bus_o[13]) ##[1:40] rom_ack) // RULE5 RULE7
		else $error("ROM shift clock without bit completion");
	rom_ack_sel_a: assert property (rom_ack |-> serial_rom_select) // RULE9
		else $error("ROM bit done without select");
	strap_pins_a: assert property (!straps_valid |-> flash_address_bus_oe == 17'h00000
		##1 (straps_valid && flash_address_bus_oe[7] && flash_address_bus_oe[1])) // RULE4 RULE8
		else $error("strap pins not released then driven");
	strap_stable_a: assert property (straps_valid |=> $stable(aux_clock_strap)
		&& $stable(standby_power_strap)) // RULE3 RULE8
		else $error("strap changed after capture");
	write_hold_a: assert property (!flash_write_enable_n |-> $stable(flash_data_bus_o)
		&& $stable(flash_address_bus_o[15:0])) // RULE12
		else $error("write data or address moved under strobe");
	flash_pins_a: assert property (straps_valid && !serial_rom_select
		|-> flash_address_bus_oe == 17'h1FFFF) // RULE2
		else $error("address pins not driven");

	read_done_c: cover property (!flash_read_enable_n ##[1:20] flash_ack);
	write_done_c: cover property (!flash_write_enable_n ##[1:20] flash_ack);
	rom_end_c: cover property (rom_ack ##[1:40] $fell(serial_rom_select));
endmodule // lfp_port

// file: tb/lfp_mem_model.sv
`timescale 1ns/1ns
module lfp_mem_model #(
	parameter logic       CLK_PULL    = 1'b1,
	parameter logic       PWR_PULL    = 1'b0,
	parameter logic [7:0] ROM_PATTERN = 8'hB4
) (
	input  wire logic [7:0]  data_o,    // Data pins from block
	input  wire logic        data_oe,   // Block drives data
	input  wire logic [16:0] addr_o,    // Address pins from block
	input  wire logic [16:0] addr_oe,   // Block drives address
	input  wire logic        rom_sel,   // Serial ROM select
	input  wire logic        sel_n,     // Flash select
	input  wire logic        rd_n,      // Flash read enable
	input  wire logic        wr_n,      // Flash write enable
	output logic      [7:0]  data_i,    // Resolved data pins
	output logic      [16:0] addr_i,    // Resolved address pins
	output logic      [15:0] last_addr, // Address of last write
	output logic      [7:0]  last_data, // Data of last write
	output logic      [7:0]  rom_rx     // Bits shifted into ROM
);
	logic [7:0] mem [0:65535];
	logic [2:0] rom_idx;

	// Bit 16 carries the clock in this setup, so only 15:0 address the array
	always @(posedge wr_n) if (sel_n === 1'b0) begin
		mem[addr_o[15:0]] = data_o;
		last_addr = addr_o[15:0];
		last_data = data_o;
	end
	always @(posedge rom_sel) begin
		rom_idx = 3'h0;
		rom_rx = 8'h00;
	end
	// Output changes on the rising shift clock; the block samples at the high half's end
	always @(posedge addr_o[15]) if (rom_sel === 1'b1) begin
		rom_rx = {rom_rx[6:0], addr_o[13]};
		rom_idx = rom_idx - 3'h1;
	end
	// Released lines show the inverse of their last level; straps are board pulls
	always_comb begin
		for (int b = 0; b < 17; b++) addr_i[b] = addr_oe[b] ? addr_o[b] : ~addr_o[b];
		if (!addr_oe[7]) addr_i[7] = CLK_PULL;
		if (!addr_oe[1]) addr_i[1] = PWR_PULL;
		if (!addr_oe[14] && rom_sel) addr_i[14] = ROM_PATTERN[rom_idx];
		data_i = data_oe ? data_o : ~data_o;
		if (!sel_n && !rd_n) data_i = mem[addr_o[15:0]];
	end
endmodule // lfp_mem_model

// file: tb/lfp_port_tb.sv
`timescale 1ns/1ns
module lfp_port_tb;
	logic                       ref_clk, reset, aux_clk_in, flash_req, flash_ack;
	logic                       rom_req, rom_di, rom_last, rom_ack, rom_do, straps_valid;
	logic                       aux_clock_strap, standby_power_strap, flash_data_bus_oe;
	logic                       serial_rom_select, flash_select_n;
	logic                       flash_read_enable_n, flash_write_enable_n;
	lfp_pkg::lfp_flash_req_type flash_cmd;
	logic [7:0]                 flash_rdata, fd_i, fd_o, rom_rx, last_data;
	logic [16:0]                fa_i, fa_o, fa_oe;
	logic [15:0]                last_addr;
	int                         n_errors, samples_checked, cycles;

	lfp_port u_lfp_port (.ref_clk(ref_clk), .reset(reset), .aux_clk_in(aux_clk_in),
		.flash_req(flash_req), .flash_cmd(flash_cmd), .flash_ack(flash_ack),
		.flash_rdata(flash_rdata), .rom_req(rom_req), .rom_di(rom_di), .rom_last(rom_last),
		.rom_ack(rom_ack), .rom_do(rom_do), .aux_clock_strap(aux_clock_strap),
		.standby_power_strap(standby_power_strap), .straps_valid(straps_valid),
		.flash_data_bus_i(fd_i), .flash_data_bus_o(fd_o), .flash_data_bus_oe(flash_data_bus_oe),
		.flash_address_bus_i(fa_i), .flash_address_bus_o(fa_o), .flash_address_bus_oe(fa_oe),
		.serial_rom_select(serial_rom_select), .flash_select_n(flash_select_n),
		.flash_read_enable_n(flash_read_enable_n), .flash_write_enable_n(flash_write_enable_n));

	lfp_mem_model u_lfp_mem_model (.data_o(fd_o), .data_oe(flash_data_bus_oe), .addr_o(fa_o),
		.addr_oe(fa_oe), .rom_sel(serial_rom_select), .sel_n(flash_select_n),
		.rd_n(flash_read_enable_n), .wr_n(flash_write_enable_n), .data_i(fd_i), .addr_i(fa_i),
		.last_addr(last_addr), .last_data(last_data), .rom_rx(rom_rx));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		aux_clk_in = 1'b0;
		forever #20 aux_clk_in = ~aux_clk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic final_report();
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic flash_op(input logic wr, input logic [16:0] a, input logic [7:0] d);
		tick(1);
		flash_cmd = '{write: wr, addr: a, wdata: d};
		flash_req = 1'b1;
		tick(2);
		check(flash_select_n, 1'b0);
		check({flash_data_bus_oe, fa_oe[15:13]}, {wr, 3'h7});
		for (int i = 0; i < 20 && flash_ack !== 1'b1; i++) tick(1);
		flash_req = 1'b0;
		check(flash_select_n, 1'b1);
	endtask

	task automatic rom_bit(input logic di, input logic last, input logic exp);
		tick(1);
		rom_di = di;
		rom_last = last;
		rom_req = 1'b1;
		tick(2);
		check(serial_rom_select, 1'b1);
		check(fa_oe[15:13], 3'h5);
		for (int i = 0; i < 60 && rom_ack !== 1'b1; i++) tick(1);
		rom_req = 1'b0;
		check(rom_do, exp);
	endtask

	task automatic scen_straps();
		tick(2);
		check({straps_valid, aux_clock_strap, standby_power_strap}, 3'h6);
		check(fa_oe, 17'h1FFFF);
		repeat (3) begin
			#7;
			check(fa_o[16], aux_clk_in);
		end
	endtask

	// Addresses chosen so the shared and strap pins take both levels
	task automatic scen_write_read();
		flash_op(1'b1, 17'h0E082, 8'hA5);
		check({last_addr, last_data}, 24'hE082A5);
		flash_op(1'b1, 17'h01D7D, 8'h3C);
		check({last_addr, last_data}, 24'h1D7D3C);
		flash_op(1'b0, 17'h0E082, 8'h00);
		check(flash_rdata, 8'hA5);
		flash_op(1'b0, 17'h01D7D, 8'h00);
		check(flash_rdata, 8'h3C);
	endtask

	// A flash request held across a ROM frame must wait for the select to drop
	task automatic scen_rom_frame();
		rom_bit(1'b1, 1'b0, 1'b1);
		flash_cmd = '{write: 1'b1, addr: 17'h00155, wdata: 8'h77};
		flash_req = 1'b1;
		rom_bit(1'b0, 1'b0, 1'b0);
		rom_bit(1'b0, 1'b0, 1'b1);
		rom_bit(1'b1, 1'b1, 1'b1);
		check(rom_rx[3:0], 4'h9);
		for (int i = 0; i < 80 && flash_ack !== 1'b1; i++) tick(1);
		flash_req = 1'b0;
		check({flash_ack, serial_rom_select}, 2'h2);
		check({last_addr, last_data}, 24'h015577);
	endtask

	// Settled mid-cycle levels, away from the edge that launches them
	always @(negedge ref_clk) begin
		cycles++;
		if (!reset) begin
			if (serial_rom_select) check(flash_select_n, 1'b1);
			if (!flash_read_enable_n)
				check({flash_data_bus_oe, flash_write_enable_n, flash_select_n}, 3'h2);
			if (!flash_write_enable_n)
				check({flash_data_bus_oe, flash_read_enable_n, flash_select_n}, 3'h6);
		end
		if (cycles > 3000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		reset = 1'b1;
		flash_req = 1'b0;
		flash_cmd = '0;
		rom_req = 1'b0;
		rom_di = 1'b0;
		rom_last = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		cycles = 0;
		tick(6);
		check({fa_oe, flash_data_bus_oe}, 18'h00000);
		check({flash_select_n, flash_read_enable_n, flash_write_enable_n, serial_rom_select},
			4'hE);
		tick(2);
		reset = 1'b0;
		scen_straps();
		scen_write_read();
		scen_rom_frame();
		final_report();
	end
endmodule // lfp_port_tb
